// ---- rtl/gripper_status_register_bank.v ----
`timescale 1ns/1ps
`include "gripper_status_map.vh"

module gripper_status_register_bank #(
    parameter [31:0] REFRESH_CYCLES = `CORE_CLK_HZ / `REFRESH_HZ,
    parameter [31:0] SPREAD_LIMIT_CYCLES = `CORE_CLK_HZ * `SPREAD_LIMIT_SEC
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // Command values seen by the core
    input  wire        activationRequest,
    input  wire [1:0]  graspModeRequest,
    input  wire        gotoRequest,
    input  wire [31:0] targetRequest,
    input  wire [31:0] forceRequest,
    // Axis measurements, axis k in byte k of the 32-bit buses and bit k of the 4-bit ones
    input  wire [31:0] axisPosition,
    input  wire [31:0] axisCurrent,
    input  wire [3:0]  contactHit,
    input  wire [3:0]  closingDir,
    input  wire [3:0]  atTarget,
    // Core condition flags
    input  wire        activationBusy,
    input  wire        modeChangeBusy,
    input  wire        activationFault,
    input  wire        commReady,
    input  wire        spreadInterference,
    input  wire        autoReleaseActive,
    input  wire        autoReleaseDone,
    // Status read port, one 16-bit word per request
    input  wire        rdReq,
    input  wire [15:0] regAddr,
    output reg  [15:0] rdData,
    output reg         rdAck,
    output reg         rdMiss,
    // Axis halt and fault indicator
    output wire [3:0]  axisHalt,
    output wire        faultSteady,
    output wire        faultBlinking
);

    // ==========================================
    // Per-axis contact hold
    // Scissor is held like a finger; only the motion summary leaves it out
    wire [7:0] contactByte;
    genvar     ax;

    generate
        for (ax = 0; ax < 4; ax = ax + 1) begin : axisGen
            axis_contact_hold holdUnit (
                .core_clk     (core_clk),
                .rst          (rst),
                .contactHit   (contactHit[ax]),
                .closingDir   (closingDir[ax]),
                .atTarget     (atTarget[ax]),
                .targetReq    (targetRequest[ax*8 +: 8]),
                .forceReq     (forceRequest[ax*8 +: 8]),
                .gotoRequest  (gotoRequest),
                .haltAxis     (axisHalt[ax]),
                .contactField (contactByte[ax*2 +: 2])
            );
        end
    endgenerate

    // ==========================================
    // Gripper state byte fields
    wire       gotoEcho;
    reg  [1:0] initState;
    reg  [1:0] motionState;
    wire [2:0] fingerHeld;
    wire [2:0] fingerSettled;

    // Go-to reads 0 while the core is busy with housekeeping
    // Busy flags come from the core on this clock, so no synchroniser
    assign gotoEcho = gotoRequest & ~activationBusy & ~modeChangeBusy & ~autoReleaseActive;

    // Initialization progress
    always @* begin
        if (!activationRequest || autoReleaseActive) begin
            initState = `INIT_RESET;
        end else if (activationBusy) begin
            initState = `INIT_ACTIVATING;
        end else if (modeChangeBusy) begin
            initState = `INIT_MODE_CHANGE;
        end else begin
            initState = `INIT_DONE;
        end
    end

    // Motion summary over the three fingers; scissor does not count
    assign fingerHeld    = axisHalt[2:0];
    assign fingerSettled = axisHalt[2:0] | atTarget[2:0];

    always @* begin
        if (!(&fingerSettled)) begin
            motionState = `MOTION_MOVING;
        end else if (fingerHeld == 3'b000) begin
            motionState = `MOTION_ALL_REACHED;
        end else if (&fingerHeld) begin
            motionState = `MOTION_ALL_EARLY;
        end else begin
            motionState = `MOTION_SOME_EARLY;
        end
    end

    // ==========================================
    // Scissor interference timer and major fault latch
    reg  [31:0] spreadCnt_reg;
    reg  [31:0] spreadCnt_next;
    reg  [3:0]  majorCode_reg;
    reg  [3:0]  majorCode_next;
    wire        spreadActive;
    wire        spreadExpired;

    // Interference outside a mode change is not timed and never escalates
    assign spreadActive  = spreadInterference & modeChangeBusy;
    assign spreadExpired = spreadActive & (spreadCnt_reg >= SPREAD_LIMIT_CYCLES);

    // Counter saturates so a stuck scissor keeps reading expired
    always @* begin
        if (!spreadActive) begin
            spreadCnt_next = 32'h00000000;
        end else if (spreadCnt_reg < SPREAD_LIMIT_CYCLES) begin
            spreadCnt_next = spreadCnt_reg + 32'h00000001;
        end else begin
            spreadCnt_next = spreadCnt_reg;
        end
    end

    // Major code holds until the controller drops activation; a new event wins
    always @* begin
        majorCode_next = majorCode_reg;
        if (autoReleaseDone) begin
            majorCode_next = `FAULT_RELEASE_DONE;
        end else if (spreadExpired) begin
            majorCode_next = `FAULT_SPREAD_MAJOR;
        end else if (activationFault) begin
            majorCode_next = `FAULT_ACT_FAIL;
        end else if (!activationRequest) begin
            majorCode_next = `FAULT_NONE;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            spreadCnt_reg <= 32'h00000000;
            majorCode_reg <= `FAULT_NONE;
        end else begin
            spreadCnt_reg <= spreadCnt_next;
            majorCode_reg <= majorCode_next;
        end
    end

    // ==========================================
    // Fault code selection: major, then priority, then minor
    // Priority codes need go-to high: they only explain a delayed motion
    reg  [3:0] faultField;
    reg        minorActive;

    always @* begin
        minorActive = 1'b0;
        if (majorCode_reg != `FAULT_NONE) begin
            faultField = majorCode_reg;
        end else if (gotoRequest && !activationRequest) begin
            faultField = `FAULT_NO_ACT;
        end else if (gotoRequest && activationBusy) begin
            faultField = `FAULT_WAIT_ACT;
        end else if (gotoRequest && modeChangeBusy) begin
            faultField = `FAULT_WAIT_MODE;
        end else if (autoReleaseActive) begin
            faultField  = `FAULT_RELEASE_RUN;
            minorActive = 1'b1;
        end else if (spreadActive) begin
            faultField  = `FAULT_SPREAD_MINOR;
            minorActive = 1'b1;
        end else if (!commReady) begin
            faultField  = `FAULT_COMM_BOOT;
            minorActive = 1'b1;
        end else begin
            faultField = `FAULT_NONE;
        end
    end

    // Indicator follows the published snapshot, not the live code
    // Only a level; the lamp driver makes the blink itself
    reg faultSteady_reg;
    reg faultBlinking_reg;

    assign faultSteady   = faultSteady_reg;
    assign faultBlinking = faultBlinking_reg;

    // ==========================================
    // Live status image, bytes assembled LSB first
    // Byte 15 pads the last word so every word read is full width
    reg [7:0] liveByte [0:`STATUS_BYTE_COUNT-1];

    always @* begin
        liveByte[`BYTE_GRIPPER_STATE]  = {motionState, initState, gotoEcho,
                                          graspModeRequest, activationRequest};
        liveByte[`BYTE_CONTACT_STATE]  = contactByte;
        liveByte[`BYTE_FAULT_CODE]     = {`FAULT_RESERVED_BITS, faultField};
        liveByte[`BYTE_FIRST_TARGET]   = targetRequest[7:0];
        liveByte[`BYTE_FIRST_POS]      = axisPosition[7:0];
        liveByte[`BYTE_FIRST_CURRENT]  = axisCurrent[7:0];
        liveByte[`BYTE_SECOND_TARGET]  = targetRequest[15:8];
        liveByte[`BYTE_SECOND_POS]     = axisPosition[15:8];
        liveByte[`BYTE_SECOND_CURRENT] = axisCurrent[15:8];
        liveByte[`BYTE_THIRD_TARGET]   = targetRequest[23:16];
        liveByte[`BYTE_THIRD_POS]      = axisPosition[23:16];
        liveByte[`BYTE_THIRD_CURRENT]  = axisCurrent[23:16];
        liveByte[`BYTE_SPREAD_TARGET]  = targetRequest[31:24];
        liveByte[`BYTE_SPREAD_POS]     = axisPosition[31:24];
        liveByte[`BYTE_SPREAD_CURRENT] = axisCurrent[31:24];
        liveByte[`BYTE_UNUSED]         = `WORD_PAD_BYTE;
    end

    // ==========================================
    // Periodic refresh; reads see a stable image between ticks
    // Default period sets the refresh rate; simulation overrides it with a short one
    reg  [31:0] refreshCnt_reg;
    reg  [7:0]  snapByte_reg [0:`STATUS_BYTE_COUNT-1];
    wire        refreshTick;
    integer     i;

    assign refreshTick = (refreshCnt_reg == 32'h00000000);

    always @(posedge core_clk) begin
        if (rst) begin
            refreshCnt_reg <= 32'h00000000;
        end else if (refreshCnt_reg >= REFRESH_CYCLES - 32'h00000001) begin
            refreshCnt_reg <= 32'h00000000;
        end else begin
            refreshCnt_reg <= refreshCnt_reg + 32'h00000001;
        end
    end

    // Snapshot taken on the first cycle after reset and every period after
    always @(posedge core_clk) begin
        if (rst) begin
            for (i = 0; i < `STATUS_BYTE_COUNT; i = i + 1) begin
                snapByte_reg[i] <= 8'h00;
            end
            faultSteady_reg   <= 1'b0;
            faultBlinking_reg <= 1'b0;
        end else if (refreshTick) begin
            for (i = 0; i < `STATUS_BYTE_COUNT; i = i + 1) begin
                snapByte_reg[i] <= liveByte[i];
            end
            faultSteady_reg   <= minorActive;
            faultBlinking_reg <= (faultField == majorCode_reg) && (majorCode_reg != `FAULT_NONE);
        end
    end

    // ==========================================
    // Word read port; there is no write path into the status image
    // A miss still answers with rdAck, so a poller never stalls
    wire [15:0] wordIdx;
    wire        wordHit;
    wire [3:0]  hiByteIdx;
    wire [3:0]  loByteIdx;

    assign wordIdx   = regAddr - `STATUS_FIRST_WORD;
    assign wordHit   = (regAddr >= `STATUS_FIRST_WORD) && (wordIdx < `STATUS_WORD_COUNT);
    assign hiByteIdx = {wordIdx[2:0], 1'b0};
    assign loByteIdx = {wordIdx[2:0], 1'b1};

    // Even byte in the high half, odd byte in the low half
    always @(posedge core_clk) begin
        if (rst) begin
            rdData <= 16'h0000;
            rdAck  <= 1'b0;
            rdMiss <= 1'b0;
        end else begin
            rdAck  <= rdReq;
            rdMiss <= rdReq & ~wordHit;
            if (rdReq && wordHit) begin
                rdData <= {snapByte_reg[hiByteIdx], snapByte_reg[loByteIdx]};
            end else if (rdReq) begin
                rdData <= 16'h0000;
            end
        end
    end

endmodule

// ---- include/gripper_status_map.vh ----
`ifndef GRIPPER_STATUS_MAP_VH
`define GRIPPER_STATUS_MAP_VH

// ==========================================
// Serial word window holding the status bytes
`define STATUS_FIRST_WORD   16'h07D0
`define STATUS_WORD_COUNT   16'h0008
`define STATUS_BYTE_COUNT   16
`define WORD_PAD_BYTE       8'h00

// ==========================================
// Status byte offsets
`define BYTE_GRIPPER_STATE  4'h0
`define BYTE_CONTACT_STATE  4'h1
`define BYTE_FAULT_CODE     4'h2
`define BYTE_FIRST_TARGET   4'h3
`define BYTE_FIRST_POS      4'h4
`define BYTE_FIRST_CURRENT  4'h5
`define BYTE_SECOND_TARGET  4'h6
`define BYTE_SECOND_POS     4'h7
`define BYTE_SECOND_CURRENT 4'h8
`define BYTE_THIRD_TARGET   4'h9
`define BYTE_THIRD_POS      4'hA
`define BYTE_THIRD_CURRENT  4'hB
`define BYTE_SPREAD_TARGET  4'hC
`define BYTE_SPREAD_POS     4'hD
`define BYTE_SPREAD_CURRENT 4'hE
`define BYTE_UNUSED         4'hF

// ==========================================
// Two-bit field values, LSB is the first printed digit
`define INIT_RESET          2'h0
`define INIT_ACTIVATING     2'h1
`define INIT_MODE_CHANGE    2'h2
`define INIT_DONE           2'h3
`define MOTION_MOVING       2'h0
`define MOTION_SOME_EARLY   2'h1
`define MOTION_ALL_EARLY    2'h2
`define MOTION_ALL_REACHED  2'h3
`define AXIS_MOVING         2'h0
`define AXIS_CONTACT_OPEN   2'h1
`define AXIS_CONTACT_CLOSE  2'h2
`define AXIS_AT_TARGET      2'h3

// ==========================================
// Fault codes
`define FAULT_NONE          4'h0
`define FAULT_WAIT_ACT      4'h5
`define FAULT_WAIT_MODE     4'h6
`define FAULT_NO_ACT        4'h7
`define FAULT_COMM_BOOT     4'h9
`define FAULT_SPREAD_MINOR  4'hA
`define FAULT_RELEASE_RUN   4'hB
`define FAULT_ACT_FAIL      4'hD
`define FAULT_SPREAD_MAJOR  4'hE
`define FAULT_RELEASE_DONE  4'hF
`define FAULT_RESERVED_BITS 4'h0

// ==========================================
// Timing
`define CORE_CLK_HZ         32'd100000000
`define REFRESH_HZ          32'd200
`define SPREAD_LIMIT_SEC    32'd20

`endif

// ---- rtl/axis_contact_hold.v ----
`timescale 1ns/1ps
`include "gripper_status_map.vh"

module axis_contact_hold (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // Axis motion inputs
    input  wire       contactHit,
    input  wire       closingDir,
    input  wire       atTarget,
    input  wire [7:0] targetReq,
    input  wire [7:0] forceReq,
    input  wire       gotoRequest,
    // Axis results
    output wire       haltAxis,
    output wire [1:0] contactField
);

    reg       held_reg;
    reg       closing_reg;
    reg       sawGotoLow_reg;
    reg [7:0] target_reg;
    reg [7:0] force_reg;
    wire      oppositeMove;
    wire      releaseNow;

    // ==========================================
    // Release conditions for a contact stop
    assign oppositeMove = closing_reg ? (targetReq < target_reg) : (targetReq > target_reg);
    assign releaseNow   = oppositeMove | (forceReq > force_reg) | (sawGotoLow_reg & gotoRequest);

    // Hold state; a new contact beats a same-cycle release
    always @(posedge core_clk) begin
        if (rst) begin
            held_reg       <= 1'b0;
            closing_reg    <= 1'b0;
            sawGotoLow_reg <= 1'b0;
            target_reg     <= 8'h00;
            force_reg      <= 8'h00;
        end else if (contactHit && gotoRequest) begin
            held_reg       <= 1'b1;
            closing_reg    <= closingDir;
            sawGotoLow_reg <= 1'b0;
            target_reg     <= targetReq;
            force_reg      <= forceReq;
        end else if (held_reg && releaseNow) begin
            held_reg       <= 1'b0;
            sawGotoLow_reg <= 1'b0;
        end else if (held_reg && !gotoRequest) begin
            sawGotoLow_reg <= 1'b1; // Only a clear then set re-arms
        end
    end

    // ==========================================
    // Per-axis contact field
    assign haltAxis     = held_reg;
    assign contactField = held_reg ? (closing_reg ? `AXIS_CONTACT_CLOSE : `AXIS_CONTACT_OPEN) :
                          atTarget ? `AXIS_AT_TARGET : `AXIS_MOVING;

endmodule

// ---- testbench/gripper_status_register_bank_asserts.sv ----
`timescale 1ns/1ps
// ==========
// Read port, contact hold and fault indicator checker
module gripper_status_register_bank_asserts #(
    parameter [31:0] REFRESH_CYCLES      = 32'h0007A120,
    parameter [31:0] SPREAD_LIMIT_CYCLES = 32'h77359400
) (
    // Clock and reset
    input wire        core_clk,
    input wire        rst,
    // Axis inputs
    input wire        gotoRequest,
    input wire [3:0]  contactHit,
    // Read port
    input wire        rdReq,
    input wire [15:0] regAddr,
    input wire [15:0] rdData,
    input wire        rdAck,
    input wire        rdMiss,
    // Halt and fault outputs
    input wire [3:0]  axisHalt,
    input wire        faultSteady,
    input wire        faultBlinking
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Word window decode, used to split hits from misses
    wire mapped = (regAddr >= 16'h07D0) && (regAddr <= 16'h07D7);

    // ==========
    // Read port
    chk_ack_latency: assert property (rdReq |=> rdAck)
        else $error("read request not answered one cycle later");
    chk_ack_cause: assert property (rdAck |-> $past(rdReq))
        else $error("read answer without a request");
    chk_miss_unmapped: assert property (rdReq && !mapped |=> rdMiss && rdData == 16'h0000)
        else $error("unmapped word not refused with zero data");
    chk_hit_mapped: assert property (rdReq && mapped |=> !rdMiss)
        else $error("mapped word flagged as a miss");
    chk_data_hold: assert property (!rdReq |=> $stable(rdData))
        else $error("read data moved without a request");
    chk_pad_byte: assert property (rdAck && $past(regAddr) == 16'h07D7 |-> rdData[7:0] == 8'h00)
        else $error("pad byte of last word not zero");

    // ==========
    // Fault byte and indicators
    chk_fault_reserved: assert property (rdAck && $past(regAddr) == 16'h07D1 |-> rdData[15:12] == 4'h0)
        else $error("reserved fault bits not zero");
    chk_blink_major: assert property (rdAck && $past(regAddr) == 16'h07D1 && rdData[11:8] >= 4'hD
        |-> $past(faultBlinking)) else $error("major code shown without blinking indicator");
    chk_fault_excl: assert property (!(faultSteady && faultBlinking))
        else $error("steady and blinking indicators both high");

    // ==========
    // Contact hold
    chk_hold_contact: assert property (gotoRequest && contactHit != 4'h0
        |=> (axisHalt & $past(contactHit)) == $past(contactHit)) else $error("contact did not halt axis");
    chk_halt_cause: assert property ($rose(axisHalt[0]) |-> $past(contactHit[0] && gotoRequest))
        else $error("axis halted without a contact under go-to");

    // Main scenarios reached
    cover property (rdMiss);
    cover property ($rose(axisHalt[0]));
    cover property ($rose(faultBlinking));
endmodule

bind gripper_status_register_bank gripper_status_register_bank_asserts #(
    .REFRESH_CYCLES(REFRESH_CYCLES), .SPREAD_LIMIT_CYCLES(SPREAD_LIMIT_CYCLES)) i_chk (
    .core_clk(core_clk), .rst(rst), .gotoRequest(gotoRequest), .contactHit(contactHit),
    .rdReq(rdReq), .regAddr(regAddr), .rdData(rdData), .rdAck(rdAck), .rdMiss(rdMiss),
    .axisHalt(axisHalt), .faultSteady(faultSteady), .faultBlinking(faultBlinking));

// ---- testbench/status_poll_ctrl.sv ----
`timescale 1ns/1ps
// ==========
// Polling controller on the status read port
module status_poll_ctrl (
    // Clock
    input  wire        core_clk,
    // Read port
    output reg         rdReq,
    output reg  [15:0] regAddr,
    input  wire [15:0] rdData,
    input  wire        rdAck,
    input  wire        rdMiss
);
    // Idle lines; address parked off the word window
    initial begin
        rdReq = 1'b0;
        regAddr = 16'hFFFF;
    end

    // One word read; the answer stands for the cycle after the taking edge
    task readWord(input [15:0] addr, output [15:0] data, output miss, output ack);
        begin
            @(negedge core_clk);
            rdReq = 1'b1;
            regAddr = addr;
            @(posedge core_clk);
            @(negedge core_clk);
            rdReq = 1'b0;
            regAddr = ~addr; // Released address never keeps its last value
            data = rdData;
            miss = rdMiss;
            ack = rdAck;
        end
    endtask
endmodule

// ---- testbench/gripper_status_register_bank_test.sv ----
`timescale 1ns/1ps
// ==========
// Status bank bench
`define CHK(got, exp) \
    begin \
        numChecks++; \
        if ((got) !== (exp)) begin \
            numErrors++; \
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module gripper_status_register_bank_test;
    // Short refresh and interference limit keep the run brief
    localparam [31:0] REF = 32'h14;
    localparam [31:0] LIM = 32'h32;
    reg         core_clk = 1'b0, rst = 1'b1, actReq = 1'b0, gotoReq = 1'b0, actBusy = 1'b0;
    reg         modeBusy = 1'b0, actFault = 1'b0, commRdy = 1'b0, spread = 1'b0, relAct = 1'b0;
    reg         relDone = 1'b0, miss, ack;
    reg  [1:0]  modeReq = 2'h0;
    reg  [3:0]  hit = 4'h0, closeDir = 4'h0, atTgt = 4'h0;
    reg  [31:0] tgtReq = 32'hFF00_7F01, frcReq = 32'h0000_0010;
    reg  [31:0] pos = 32'h00FF_3C5A, cur = 32'h8001_FEC3;
    reg  [15:0] word;
    wire        rdReq, rdAck, rdMiss, faultSteady, faultBlinking;
    wire [15:0] regAddr, rdData;
    wire [3:0]  axisHalt;
    integer     numErrors = 0, numChecks = 0, m;

    gripper_status_register_bank #(.REFRESH_CYCLES(REF), .SPREAD_LIMIT_CYCLES(LIM)) i_dut (
        .core_clk(core_clk), .rst(rst), .activationRequest(actReq), .graspModeRequest(modeReq),
        .gotoRequest(gotoReq), .targetRequest(tgtReq), .forceRequest(frcReq), .axisPosition(pos),
        .axisCurrent(cur), .contactHit(hit), .closingDir(closeDir), .atTarget(atTgt),
        .activationBusy(actBusy), .modeChangeBusy(modeBusy), .activationFault(actFault),
        .commReady(commRdy), .spreadInterference(spread), .autoReleaseActive(relAct),
        .autoReleaseDone(relDone), .rdReq(rdReq), .regAddr(regAddr), .rdData(rdData), .rdAck(rdAck),
        .rdMiss(rdMiss), .axisHalt(axisHalt), .faultSteady(faultSteady), .faultBlinking(faultBlinking));

    status_poll_ctrl i_ctrl (.core_clk(core_clk), .rdReq(rdReq), .regAddr(regAddr), .rdData(rdData),
        .rdAck(rdAck), .rdMiss(rdMiss));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // ==========
    // Tasks
    task conclude;
        begin
            $display("checks %0d errors %0d", numChecks, numErrors);
            if (numErrors == 0 && numChecks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task rd(input [15:0] addr, input [15:0] exp);
        begin
            i_ctrl.readWord(addr, word, miss, ack);
            `CHK(ack, 1'b1)
            `CHK(word, exp)
        end
    endtask

    // Wait past one refresh so the snapshot holds the new inputs
    task settle;
        repeat (REF + 3) @(negedge core_clk);
    endtask

    task fault(input [3:0] code, input blink);
        begin
            rd(16'h07D1, {4'h0, code, tgtReq[7:0]});
            `CHK(faultBlinking, blink)
        end
    endtask

    // Whole image; bytes packed big endian into even-high words
    task chkAll(input [7:0] b0, input [7:0] b1, input [7:0] b2);
        reg [7:0] b [0:15];
        integer k;
        begin
            b[0] = b0;
            b[1] = b1;
            b[2] = b2;
            b[15] = 8'h00;
            for (k = 0; k < 4; k++) begin
                b[3*k+3] = tgtReq[8*k +: 8];
                b[3*k+4] = pos[8*k +: 8];
                b[3*k+5] = cur[8*k +: 8];
            end
            for (k = 0; k < 8; k++)
                rd(16'h07D0 + k[15:0], {b[2*k], b[2*k+1]});
        end
    endtask

    // One-cycle contact pulse on the first axis
    task hold(input dirClose);
        begin
            hit = 4'h1;
            closeDir = {3'h0, dirClose};
            @(negedge core_clk);
            hit = 4'h0;
            `CHK(axisHalt, 4'h1)
        end
    endtask

    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        numErrors++;
        conclude;
    end

    // ==========
    // Main sequence
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        settle;
        chkAll(8'h00, 8'h00, 8'h09);
        `CHK(faultSteady, 1'b1)
        rd(16'h07D8, 16'h0000);
        `CHK(miss, 1'b1)
        rd(16'h07CF, 16'h0000);
        `CHK(miss, 1'b1)
        commRdy = 1'b1;
        actReq = 1'b1;
        actBusy = 1'b1;
        gotoReq = 1'b1;
        settle;
        chkAll(8'h11, 8'h00, 8'h05);
        actBusy = 1'b0;
        modeBusy = 1'b1;
        for (m = 0; m < 4; m++) begin
            modeReq = m[1:0];
            settle;
            rd(16'h07D0, {8'h21 | {5'h00, modeReq, 1'b0}, 8'h00});
            fault(4'h6, 1'b0);
        end
        modeBusy = 1'b0;
        modeReq = 2'h0;
        atTgt = 4'hF;
        settle;
        chkAll(8'hF9, 8'hFF, 8'h00);
        actReq = 1'b0;
        settle;
        fault(4'h7, 1'b0);
        // Contact ignored while go-to is low, then held and released three ways
        actReq = 1'b1;
        atTgt = 4'hE;
        gotoReq = 1'b0;
        hit = 4'h1;
        @(negedge core_clk);
        hit = 4'h0;
        `CHK(axisHalt, 4'h0)
        gotoReq = 1'b1;
        @(negedge core_clk);
        hold(1'b1);
        settle;
        rd(16'h07D0, 16'h79FE);
        tgtReq[7:0] = 8'h05;
        repeat (2) @(negedge core_clk);
        `CHK(axisHalt, 4'h1)
        frcReq[7:0] = 8'h11;
        @(negedge core_clk);
        `CHK(axisHalt, 4'h0)
        hold(1'b0);
        tgtReq[7:0] = 8'h06;
        @(negedge core_clk);
        `CHK(axisHalt, 4'h0)
        hold(1'b1);
        gotoReq = 1'b0;
        @(negedge core_clk);
        `CHK(axisHalt, 4'h1)
        gotoReq = 1'b1;
        @(negedge core_clk);
        `CHK(axisHalt, 4'h0)
        // All fingers stopped on contact while opening, then freed by more force
        hit = 4'h7;
        closeDir = 4'h0;
        @(negedge core_clk);
        hit = 4'h0;
        settle;
        rd(16'h07D0, 16'hB9D5);
        frcReq[23:0] = 24'h222222;
        @(negedge core_clk);
        `CHK(axisHalt, 4'h0)
        // Minor, escalated and latched major faults
        atTgt = 4'hF;
        relAct = 1'b1;
        settle;
        fault(4'hB, 1'b0);
        `CHK(faultSteady, 1'b1)
        rd(16'h07D0, 16'hC1FF);
        relAct = 1'b0;
        gotoReq = 1'b0;
        modeBusy = 1'b1;
        spread = 1'b1;
        settle;
        fault(4'hA, 1'b0);
        `CHK(faultSteady, 1'b1)
        repeat (LIM) @(negedge core_clk);
        settle;
        fault(4'hE, 1'b1);
        spread = 1'b0;
        modeBusy = 1'b0;
        settle;
        fault(4'hE, 1'b1);
        for (m = 0; m < 2; m++) begin
            actReq = 1'b0;
            settle;
            fault(4'h0, 1'b0);
            actReq = 1'b1;
            actFault = (m == 0);
            relDone = (m == 1);
            settle;
            fault(m == 0 ? 4'hD : 4'hF, 1'b1);
            actFault = 1'b0;
            relDone = 1'b0;
        end
        conclude;
    end
endmodule
